/* rtl/tilt_threshold_relay_trigger.sv */
// tilt_threshold_relay_trigger: threshold conditions on two tilt axes driving two relays
// assumes angles from logic on clk_sys, in signed tenths of a degree,
// and an ahb-lite master on the same clock
`timescale 1ns/1ps
`default_nettype none

module tilt_threshold_relay_trigger
  import tilt_relay_pkg::*;
#(
  parameter int unsigned STEP_CYCLES_P = STEP_CYCLES,
  parameter logic [STEPS_W-1:0] MAX_DELAY_STEPS = FACTORY_MAX_STEPS,
  parameter bit NORMALLY_OPEN = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // ahb-lite register slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // measured angles
  input wire logic signed [ANGLE_W-1:0] first_axis_inclination,
  input wire logic signed [ANGLE_W-1:0] second_axis_inclination,
  // relay contacts and interrupt
  output logic [NUM_RELAYS-1:0] relay_contact_closed,
  output logic irq
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic dual_axis;
    link_code_t link_code;
    logic [NUM_RELAYS-1:0][LOGIC_FIELD_W-1:0] and_ops;
    logic [NUM_RELAYS-1:0][STEPS_W-1:0] on_steps;
    logic [NUM_RELAYS-1:0][STEPS_W-1:0] off_steps;
    logic [NUM_CONDS-1:0] cond_en;
    logic [NUM_CONDS-1:0] cond_gt;
    logic [HYST_W-1:0] hyst;
    logic [NUM_CONDS-1:0][ANGLE_W-1:0] thr;
    logic [NUM_CONDS-1:0] cond_state;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [NUM_RELAYS-1:0] act_prev;
    logic wr_pend;
    logic wr_hit;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] rdata;
  } regs_t;

  regs_t state;
  regs_t next_state;

  logic [NUM_AXES-1:0][ANGLE_W-1:0] ax_angle;
  logic [NUM_CONDS-1:0] cond_eval;
  logic [NUM_RELAYS-1:0] activated;
  logic [NUM_RELAYS-1:0] trigger;
  logic [31:0] rd_value;
  logic accept;
  logic addr_ok;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [ANGLE_W-1:0] wrap_half_turn(input logic signed [ANGLE_W-1:0] a);
    logic signed [ANGLE_W-1:0] r;
    r = a;
    if (a > HALF_TURN) begin
      r = a - FULL_TURN;
    end else if (a < -HALF_TURN) begin
      r = a + FULL_TURN;
    end
    return r;
  endfunction

  function automatic logic [ANGLE_W-1:0] clamp_quarter(input logic signed [ANGLE_W-1:0] a);
    logic signed [ANGLE_W-1:0] r;
    r = a;
    if (a > QUARTER_TURN) begin
      r = QUARTER_TURN;
    end else if (a < -QUARTER_TURN) begin
      r = -QUARTER_TURN;
    end
    return r;
  endfunction

  function automatic logic [STEPS_W-1:0] clamp_steps(input logic [STEPS_W-1:0] s);
    return (s > MAX_DELAY_STEPS) ? MAX_DELAY_STEPS : s;
  endfunction

  function automatic logic [HYST_W-1:0] clamp_hyst(input logic [HYST_W-1:0] h);
    logic [HYST_W-1:0] r;
    r = h;
    if (h < HYST_MIN) begin
      r = HYST_MIN;
    end else if (h > HYST_MAX) begin
      r = HYST_MAX;
    end
    return r;
  endfunction

  // slots of {second axis, first axis} that a relay listens to
  function automatic logic [NUM_CONDS-1:0] route_mask(input link_code_t code, input bit relay);
    logic [NUM_SLOTS-1:0] a1;
    logic [NUM_SLOTS-1:0] a2;
    a1 = SLOTS_NONE;
    a2 = SLOTS_NONE;
    case (code)
      link_code_single_relay: begin
        if (!relay) begin
          a1 = SLOTS_ONE_THREE;
          a2 = SLOTS_ONE_THREE;
        end
      end
      link_code_split_axes: begin
        if (!relay) begin
          a1 = SLOTS_ONE_THREE;
        end else begin
          a2 = SLOTS_ONE_THREE;
        end
      end
      link_code_dual_both_axes: begin
        a1 = relay ? SLOTS_TWO_FOUR : SLOTS_ONE_THREE;
        a2 = relay ? SLOTS_TWO_FOUR : SLOTS_ONE_THREE;
      end
      link_code_first_axis_pairs: begin
        a1 = relay ? SLOTS_TWO_FOUR : SLOTS_ONE_THREE;
      end
      link_code_first_axis_thresholds: begin
        a1 = relay ? SLOT_THREE : SLOT_ONE;
      end
      link_code_second_axis_pairs: begin
        a2 = relay ? SLOTS_TWO_FOUR : SLOTS_ONE_THREE;
      end
      link_code_single_thresholds: begin
        a2 = relay ? SLOT_THREE : SLOT_ONE;
      end
      default: begin
        // unused code: no relay listens to anything
        a1 = SLOTS_NONE;
      end
    endcase
    return {a2, a1};
  endfunction

  // ****************************************
  // angle range handling
  // ****************************************
  always_comb begin
    ax_angle[0] = wrap_half_turn(first_axis_inclination);
    if (state.dual_axis) begin
      ax_angle[1] = clamp_quarter(second_axis_inclination);
    end else begin
      ax_angle[1] = wrap_half_turn(second_axis_inclination);
    end
  end

  // ****************************************
  // threshold conditions
  // ****************************************
  for (genvar i = 0; i < NUM_CONDS; i++) begin : g_cond
    logic signed [ANGLE_W:0] ang;
    logic signed [ANGLE_W:0] thr;
    logic signed [ANGLE_W:0] hys;
    // first four slots watch the first axis, the rest the second
    assign ang = $signed({ax_angle[i / NUM_SLOTS][ANGLE_W-1], ax_angle[i / NUM_SLOTS]});
    assign thr = $signed({state.thr[i][ANGLE_W-1], state.thr[i]});
    assign hys = $signed({{(ANGLE_W + 1 - HYST_W){1'b0}}, state.hyst});
    // the band only widens the condition while it is already met
    assign cond_eval[i] = state.cond_gt[i]
      ? ((ang > thr) || (state.cond_state[i] && (ang > thr - hys)))
      : ((ang < thr) || (state.cond_state[i] && (ang < thr + hys)));
  end

  // ****************************************
  // relay triggers and delays
  // ****************************************
  for (genvar r = 0; r < NUM_RELAYS; r++) begin : g_relay
    relay_delay_if dly ();
    logic [NUM_CONDS-1:0] used;
    logic [NUM_AXES-1:0] ax_act;
    logic [NUM_AXES-1:0] ax_val;

    assign used = route_mask(state.link_code, r[0]) & state.cond_en;

    for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
      logic [NUM_SLOTS-1:0] u;
      logic [NUM_SLOTS-1:0] c;
      assign u = used[a * NUM_SLOTS +: NUM_SLOTS];
      assign c = state.cond_state[a * NUM_SLOTS +: NUM_SLOTS];
      assign ax_act[a] = |u;
      // masked slots are neutral for either operator
      assign ax_val[a] = state.and_ops[r][a] ? &(c | ~u) : |(c & u);
    end

    // an axis with nothing enabled drops out of the cross term
    assign dly.trigger = (&ax_act)
      ? (state.and_ops[r][LOGIC_CROSS_BIT] ? &ax_val : |ax_val)
      : |(ax_act & ax_val);
    assign dly.on_steps = state.on_steps[r];
    assign dly.off_steps = state.off_steps[r];
    assign trigger[r] = dly.trigger;
    assign activated[r] = dly.activated;

    relay_delay_timer #(
      .STEP_CYCLES_P(STEP_CYCLES_P)
    ) u_timer (
      .clk_sys(clk_sys),
      .rst(rst),
      .link(dly.timer)
    );
  end

  // ****************************************
  // register read mux
  // ****************************************
  assign addr_ok = (haddr[31:ADDR_W] == '0);
  assign accept = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);

  always_comb begin
    rd_value = '0;
    case (haddr[ADDR_W-1:0])
      REG_CTRL: begin
        rd_value[CTRL_DUAL_BIT] = state.dual_axis;
        rd_value[CTRL_LINK_LSB +: 3] = state.link_code;
      end
      REG_LOGIC: rd_value[NUM_RELAYS * LOGIC_FIELD_W - 1:0] = state.and_ops;
      REG_DELAY: begin
        for (int r = 0; r < NUM_RELAYS; r++) begin
          rd_value[r * DELAY_RELAY_W +: STEPS_W] = state.on_steps[r];
          rd_value[r * DELAY_RELAY_W + DELAY_OFF_LSB +: STEPS_W] = state.off_steps[r];
        end
      end
      REG_COND: rd_value[COND_GT_LSB + NUM_CONDS - 1:0] = {state.cond_gt, state.cond_en};
      REG_HYST: rd_value[HYST_W-1:0] = state.hyst;
      REG_STATUS: begin
        rd_value[NUM_RELAYS-1:0] = activated;
        rd_value[STATUS_TRIG_LSB +: NUM_RELAYS] = trigger;
        rd_value[STATUS_COND_LSB +: NUM_CONDS] = state.cond_state;
      end
      REG_IRQ_STATUS: rd_value[IRQ_W-1:0] = state.irq_status;
      REG_IRQ_ENABLE: rd_value[IRQ_W-1:0] = state.irq_enable;
      REG_ANGLE: rd_value = {ax_angle[1], ax_angle[0]};
      default: begin
        if (haddr[ADDR_W-1:THR_BLOCK_LSB] == REG_THR_BASE[ADDR_W-1:THR_BLOCK_LSB]) begin
          rd_value[ANGLE_W-1:0] = state.thr[haddr[THR_IDX_LSB +: THR_IDX_W]];
        end
      end
    endcase
    if (!addr_ok) begin
      rd_value = '0;
    end
  end

  // ****************************************
  // next state: bus writes, conditions, events
  // ****************************************
  always_comb begin
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    next_state = state;
    irq_set = {~activated & state.act_prev, activated & ~state.act_prev};
    irq_clr = '0;
    next_state.cond_state = cond_eval;
    next_state.act_prev = activated;

    // data phase of a write: one wait state, then the value lands
    if (state.wr_pend) begin
      next_state.wr_pend = 1'b0;
      if (state.wr_hit) begin
        case (state.wr_addr)
          REG_CTRL: begin
            next_state.dual_axis = hwdata[CTRL_DUAL_BIT];
            next_state.link_code = link_code_t'(hwdata[CTRL_LINK_LSB +: 3]);
          end
          REG_LOGIC: begin
            next_state.and_ops = hwdata[NUM_RELAYS * LOGIC_FIELD_W - 1:0];
          end
          REG_DELAY: begin
            for (int r = 0; r < NUM_RELAYS; r++) begin
              next_state.on_steps[r] = clamp_steps(hwdata[r * DELAY_RELAY_W +: STEPS_W]);
              next_state.off_steps[r] =
                clamp_steps(hwdata[r * DELAY_RELAY_W + DELAY_OFF_LSB +: STEPS_W]);
            end
          end
          REG_COND: begin
            next_state.cond_en = hwdata[NUM_CONDS-1:0];
            next_state.cond_gt = hwdata[COND_GT_LSB +: NUM_CONDS];
          end
          REG_HYST: next_state.hyst = clamp_hyst(hwdata[HYST_W-1:0]);
          REG_IRQ_CLEAR: irq_clr = hwdata[IRQ_W-1:0];
          REG_IRQ_ENABLE: next_state.irq_enable = hwdata[IRQ_W-1:0];
          default: begin
            if (state.wr_addr[ADDR_W-1:THR_BLOCK_LSB] ==
                REG_THR_BASE[ADDR_W-1:THR_BLOCK_LSB]) begin
              next_state.thr[state.wr_addr[THR_IDX_LSB +: THR_IDX_W]] =
                hwdata[ANGLE_W-1:0];
            end
          end
        endcase
      end
    end

    // address phase
    if (accept) begin
      if (hwrite) begin
        next_state.wr_pend = 1'b1;
        next_state.wr_hit = addr_ok;
        next_state.wr_addr = haddr[ADDR_W-1:0];
      end else begin
        next_state.rdata = rd_value;
      end
    end

    // a new event wins over a clear in the same cycle
    next_state.irq_status = (state.irq_status & ~irq_clr) | irq_set;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= '0;
      state.link_code <= LINK_RESET;
      state.hyst <= HYST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign hreadyout = ~state.wr_pend;
  assign hresp = 1'b0;
  assign hrdata = state.rdata;
  assign irq = |(state.irq_status & state.irq_enable);
  // unactivated closes the contact in the normally-closed build
  assign relay_contact_closed = NORMALLY_OPEN ? activated : ~activated;

endmodule

`default_nettype wire

/* inc/tilt_relay_pkg.sv */
// tilt_relay_pkg: constants, register map and types of the tilt relay trigger
// assumes one 100 MHz system clock and an ahb-lite register bus with 32-bit data

package tilt_relay_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_RELAYS = 2;
  localparam int NUM_AXES = 2;
  localparam int NUM_SLOTS = 4;
  localparam int NUM_CONDS = NUM_AXES * NUM_SLOTS;
  localparam int ANGLE_W = 16;
  localparam int STEPS_W = 6;
  localparam int HYST_W = 8;
  localparam int ADDR_W = 8;
  localparam int LOGIC_FIELD_W = 3;
  localparam int IRQ_W = 2 * NUM_RELAYS;

  // ****************************************
  // angles in signed tenths of a degree
  // ****************************************
  localparam logic signed [ANGLE_W-1:0] FULL_TURN = 16'sh0E10;
  localparam logic signed [ANGLE_W-1:0] HALF_TURN = 16'sh0708;
  localparam logic signed [ANGLE_W-1:0] QUARTER_TURN = 16'sh0384;
  localparam logic [HYST_W-1:0] HYST_MIN = 8'h01;
  localparam logic [HYST_W-1:0] HYST_MAX = 8'h64;
  localparam logic [HYST_W-1:0] HYST_RESET = 8'h0A;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 32'h0000_000A;
  localparam int unsigned STEP_TIME_MS = 32'h0000_01F4;
  localparam int unsigned NS_PER_MS = 32'h000F_4240;
  localparam int unsigned STEP_CYCLES = STEP_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam logic [STEPS_W-1:0] FACTORY_MAX_STEPS = 6'h04;
  localparam logic [STEPS_W-1:0] PROSE_MAX_STEPS = 6'h28;

  // ****************************************
  // linking codes and slot masks
  // ****************************************
  typedef enum logic [2:0] {
    link_code_single_relay = 3'h0,
    link_code_split_axes = 3'h1,
    link_code_dual_both_axes = 3'h2,
    link_code_first_axis_pairs = 3'h3,
    link_code_first_axis_thresholds = 3'h4,
    link_code_second_axis_pairs = 3'h5,
    link_code_single_thresholds = 3'h6
  } link_code_t;

  localparam logic [NUM_SLOTS-1:0] SLOTS_NONE = 4'h0;
  localparam logic [NUM_SLOTS-1:0] SLOT_ONE = 4'h1;
  localparam logic [NUM_SLOTS-1:0] SLOT_THREE = 4'h4;
  localparam logic [NUM_SLOTS-1:0] SLOTS_ONE_THREE = 4'h5;
  localparam logic [NUM_SLOTS-1:0] SLOTS_TWO_FOUR = 4'hA;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_LOGIC = 8'h04;
  localparam logic [ADDR_W-1:0] REG_DELAY = 8'h08;
  localparam logic [ADDR_W-1:0] REG_COND = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_HYST = 8'h10;
  localparam logic [ADDR_W-1:0] REG_THR_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h40;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h44;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 8'h48;
  localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h4C;
  localparam logic [ADDR_W-1:0] REG_ANGLE = 8'h50;
  localparam int THR_IDX_LSB = 2;
  localparam int THR_IDX_W = 3;
  localparam int THR_BLOCK_LSB = THR_IDX_LSB + THR_IDX_W;
  localparam int CTRL_DUAL_BIT = 0;
  localparam int CTRL_LINK_LSB = 1;
  localparam int LOGIC_CROSS_BIT = 2;
  localparam int DELAY_RELAY_W = 16;
  localparam int DELAY_OFF_LSB = 8;
  localparam int COND_GT_LSB = 8;
  localparam int STATUS_TRIG_LSB = 2;
  localparam int STATUS_COND_LSB = 4;
  localparam int ANGLE_SECOND_LSB = 16;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam link_code_t LINK_RESET = link_code_dual_both_axes;

endpackage

/* inc/relay_delay_if.sv */
// relay_delay_if: one relay's trigger and delay settings, and its delayed state
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none

interface relay_delay_if import tilt_relay_pkg::*; ();
  logic trigger;
  logic [STEPS_W-1:0] on_steps;
  logic [STEPS_W-1:0] off_steps;
  logic activated;

  modport ctrl (output trigger, output on_steps, output off_steps, input activated);
  modport timer (input trigger, input on_steps, input off_steps, output activated);
endinterface

`default_nettype wire

/* rtl/relay_delay_timer.sv */
// relay_delay_timer: applies the on-delay and off-delay to one relay trigger
// assumes trigger and step counts come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module relay_delay_timer
  import tilt_relay_pkg::*;
#(
  parameter int unsigned STEP_CYCLES_P = STEP_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // trigger in, delayed state out
  relay_delay_if.timer link
);

  typedef struct packed {
    logic activated;
    logic [31:0] count;
  } timer_state_t;

  timer_state_t state;
  timer_state_t next_state;
  logic [31:0] limit;

  // ****************************************
  // delay counting
  // ****************************************
  always_comb begin
    next_state = state;
    limit = state.activated ? 32'(link.off_steps) * STEP_CYCLES_P
                            : 32'(link.on_steps) * STEP_CYCLES_P;
    if (link.trigger == state.activated) begin
      // a trigger that falls back restarts the wait
      next_state.count = '0;
    end else if (state.count >= limit) begin
      next_state.activated = link.trigger;
      next_state.count = '0;
    end else begin
      next_state.count = state.count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign link.activated = state.activated;

endmodule

`default_nettype wire

/* tb/tilt_relay_sva.sv */
// tilt_relay_sva: bus, reset, interrupt and relay timing properties
// assumes one ahb-lite master whose hready is our own hreadyout
`timescale 1ns/1ps
`default_nettype none

module tilt_relay_sva
  import tilt_relay_pkg::*;
#(
  parameter int unsigned STEP_CYCLES_P = STEP_CYCLES,
  parameter logic [STEPS_W-1:0] MAX_DELAY_STEPS = FACTORY_MAX_STEPS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // angles, contacts, interrupt
  input wire logic signed [ANGLE_W-1:0] first_axis_inclination,
  input wire logic signed [ANGLE_W-1:0] second_axis_inclination,
  input wire logic [NUM_RELAYS-1:0] relay_contact_closed,
  input wire logic irq
);
  // ****************************************
  // helpers
  // ****************************************
  localparam int unsigned LIMIT = MAX_DELAY_STEPS * STEP_CYCLES_P + 6;
  logic wr_take;
  logic rd_take;
  logic signed [ANGLE_W-1:0] a1_q;
  logic signed [ANGLE_W-1:0] a2_q;
  int unsigned quiet;

  assign wr_take = hsel && hready && htrans[1] && hsize == HSIZE_WORD && hwrite;
  assign rd_take = hsel && hready && htrans[1] && hsize == HSIZE_WORD && !hwrite;

  // cycles since the last angle change or register write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      a1_q <= '0;
      a2_q <= '0;
      quiet <= '0;
    end else begin
      a1_q <= first_axis_inclination;
      a2_q <= second_axis_inclination;
      if (!hreadyout || a1_q != first_axis_inclination || a2_q != second_axis_inclination)
        quiet <= '0;
      else if (quiet < LIMIT)
        quiet <= quiet + 1;
    end
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_stall;
    !hreadyout ##1 hreadyout;
  endsequence

  chk_hresp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  chk_write_stall: assert property (wr_take |=> s_stall)
    else $error("write data phase not one wait state");
  chk_read_nowait: assert property (rd_take |=> hreadyout)
    else $error("read data phase stalled");
  chk_stall_cause: assert property (!hreadyout |-> $past(wr_take))
    else $error("stall without a write");
  chk_rdata_hold: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");
  chk_reset_safe: assert property ($fell(rst) |-> relay_contact_closed == '1 && !irq)
    else $error("outputs not idle after reset");
  chk_irq_cause: assert property ($rose(irq) |-> !$past(hreadyout)
    || $past(relay_contact_closed) != $past(relay_contact_closed, 2))
    else $error("interrupt rose without cause");
  chk_irq_drop: assert property ($fell(irq) |-> !$past(hreadyout))
    else $error("interrupt fell without a write");
  chk_contact_cause: assert property ($changed(relay_contact_closed) |-> quiet < LIMIT)
    else $error("contact moved long after any change");
endmodule

bind tilt_threshold_relay_trigger tilt_relay_sva #(
  .STEP_CYCLES_P(STEP_CYCLES_P),
  .MAX_DELAY_STEPS(MAX_DELAY_STEPS)
) chk (
  .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .first_axis_inclination(first_axis_inclination),
  .second_axis_inclination(second_axis_inclination),
  .relay_contact_closed(relay_contact_closed), .irq(irq)
);

`default_nettype wire

/* tb/relay_eval_unit.sv */
// relay_eval_unit: evaluation unit that reads the two relay contacts
// assumes contacts settle within one system clock
`timescale 1ns/1ps
`default_nettype none

module relay_eval_unit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // contacts in, signal seen out
  input wire logic [1:0] contact_closed,
  output logic [1:0] signal_seen
);
  // ****************************************
  // a closed contact carries the signal
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      signal_seen <= 2'b11;
    else
      signal_seen <= contact_closed;
  end
endmodule

`default_nettype wire

/* tb/tilt_threshold_relay_trigger_tb_top.sv */
// tilt_threshold_relay_trigger_tb_top: register-level tests of the tilt relay trigger
// assumes four clocks per delay step and the factory delay range
`timescale 1ns/1ps
`default_nettype none

module tilt_threshold_relay_trigger_tb_top
  import tilt_relay_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic signed [ANGLE_W-1:0] ang1 = '0;
  logic signed [ANGLE_W-1:0] ang2 = '0;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic [31:0] hrdata;
  logic [1:0] relay_contact_closed;
  logic [1:0] signal_seen;
  int err_total = 0;
  int num_checks = 0;
  logic [7:0] ra [11] = '{REG_CTRL, REG_LOGIC, REG_DELAY, REG_COND, REG_HYST, REG_THR_BASE,
    REG_STATUS, REG_IRQ_STATUS, REG_IRQ_ENABLE, 8'h14, 8'h80};
  logic [31:0] rv [11] = '{32'h0000_0004, '0, '0, '0, 32'h0000_000A, '0, '0, '0, '0, '0, '0};

  always #5 clk_sys = ~clk_sys;

  tilt_threshold_relay_trigger #(
    .STEP_CYCLES_P(4), .MAX_DELAY_STEPS(FACTORY_MAX_STEPS), .NORMALLY_OPEN(1'b0)
  ) uut (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .first_axis_inclination(ang1), .second_axis_inclination(ang2),
    .relay_contact_closed(relay_contact_closed), .irq(irq)
  );

  relay_eval_unit far (.clk_sys(clk_sys), .rst(rst), .contact_closed(relay_contact_closed),
    .signal_seen(signal_seen));

  // ****************************************
  // verdict, compare and bus tasks
  // ****************************************
  task close_out;
    if (err_total == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask

  // wait for a rising edge with hready high; hready and data are sampled at the falling edge before it
  task rdy_edge(output logic [31:0] d);
    int n;
    logic r;
    n = 0;
    r = 1'b0;
    while (r !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      r = hreadyout;
      d = hrdata;
      n++;
      @(posedge clk_sys);
    end
    if (r !== 1'b1)
      check({31'h0, r}, 32'h1);
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    rdy_edge(d);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rdy_edge(d);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, e);
  endtask

  task relay_chk(input logic [1:0] e, input logic ei);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check({30'h0, relay_contact_closed}, {30'h0, e});
    check({30'h0, signal_seen}, {30'h0, e});
    check({31'h0, irq}, {31'h0, ei});
    @(posedge clk_sys);
  endtask

  // edges from the angle change until relay one shows level v
  task meas(input logic v, input int exp);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      @(negedge clk_sys);
    end while (relay_contact_closed[0] !== v && n < 100);
    @(posedge clk_sys);
    check(n, exp);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    #200000;
    err_total++;
    close_out;
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    relay_chk(2'b11, 1'b0);
    wr(8'h14, 32'hFFFF_FFFF);
    wr(REG_STATUS, 32'hFFFF_FFFF);
    wr(REG_IRQ_STATUS, 32'hFFFF_FFFF);
    for (int i = 0; i < 11; i++) begin
      rd(ra[i], rv[i]);
    end
    wr(REG_DELAY, 32'h3F3F_3F3F);
    rd(REG_DELAY, 32'h0404_0404);
    wr(REG_HYST, 32'h0000_00FF);
    rd(REG_HYST, 32'h0000_0064);
    wr(REG_HYST, 32'h0000_0000);
    rd(REG_HYST, 32'h0000_0001);
    wr(REG_HYST, 32'h0000_000A);
    wr(REG_DELAY, 32'h0000_0000);
    wr(REG_THR_BASE, 32'h0000_01C2);
    wr(REG_THR_BASE + 8'h04, 32'h0000_01C2);
    wr(REG_THR_BASE + 8'h08, 32'h0000_FE3E);
    wr(REG_THR_BASE + 8'h10, 32'h0000_01C2);
    rd(REG_THR_BASE + 8'h10, 32'h0000_01C2);
    ang1 <= 16'sh01F4;
    relay_chk(2'b11, 1'b0);
    wr(REG_COND, 32'h0000_0101);
    relay_chk(2'b10, 1'b0);
    rd(REG_STATUS, 32'h0000_0115);
    ang1 <= 16'sh01BD;
    relay_chk(2'b10, 1'b0);
    ang1 <= 16'sh01B8;
    relay_chk(2'b11, 1'b0);
    ang1 <= 16'sh01F4;
    wr(REG_COND, 32'h0000_0105);
    relay_chk(2'b10, 1'b0);
    wr(REG_LOGIC, 32'h0000_0001);
    relay_chk(2'b11, 1'b0);
    wr(REG_LOGIC, 32'h0000_0000);
    wr(REG_COND, 32'h0000_1111);
    relay_chk(2'b10, 1'b0);
    wr(REG_LOGIC, 32'h0000_0004);
    relay_chk(2'b11, 1'b0);
    ang2 <= 16'sh01F4;
    relay_chk(2'b10, 1'b0);
    ang2 <= 16'sh0000;
    wr(REG_LOGIC, 32'h0000_0000);
    wr(REG_COND, 32'h0000_0202);
    relay_chk(2'b01, 1'b0);
    wr(REG_CTRL, 32'h0000_0006);
    relay_chk(2'b01, 1'b0);
    wr(REG_CTRL, 32'h0000_0000);
    relay_chk(2'b11, 1'b0);
    wr(REG_CTRL, 32'h0000_000C);
    relay_chk(2'b11, 1'b0);
    wr(REG_CTRL, 32'h0000_0004);
    wr(REG_COND, 32'h0000_0000);
    wr(REG_IRQ_CLEAR, 32'h0000_000F);
    rd(REG_IRQ_STATUS, 32'h0000_0000);
    wr(REG_IRQ_ENABLE, 32'h0000_0001);
    wr(REG_COND, 32'h0000_0101);
    relay_chk(2'b10, 1'b1);
    rd(REG_IRQ_STATUS, 32'h0000_0001);
    wr(REG_IRQ_ENABLE, 32'h0000_0000);
    relay_chk(2'b10, 1'b0);
    wr(REG_IRQ_ENABLE, 32'h0000_0001);
    relay_chk(2'b10, 1'b1);
    wr(REG_IRQ_CLEAR, 32'h0000_0001);
    relay_chk(2'b10, 1'b0);
    wr(REG_COND, 32'h0000_0000);
    relay_chk(2'b11, 1'b0);
    rd(REG_IRQ_STATUS, 32'h0000_0004);
    wr(REG_IRQ_ENABLE, 32'h0000_0000);
    wr(REG_DELAY, 32'h0000_0102);
    ang1 <= 16'sh0000;
    wr(REG_COND, 32'h0000_0101);
    ang1 <= 16'sh01F4;
    meas(1'b0, 10);
    ang1 <= 16'sh0000;
    meas(1'b1, 6);
    ang1 <= 16'sh01F4;
    meas(1'b0, 10);
    ang1 <= 16'sh0000;
    repeat (2) @(posedge clk_sys);
    ang1 <= 16'sh01F4;
    meas(1'b1, 100);
    wr(REG_CTRL, 32'h0000_0005);
    ang1 <= 16'sh07D0;
    ang2 <= 16'sh04B0;
    rd(REG_ANGLE, 32'h0384_F9C0);
    ang2 <= 16'shFB50;
    rd(REG_ANGLE, 32'hFC7C_F9C0);
    wr(REG_CTRL, 32'h0000_0004);
    rd(REG_ANGLE, 32'hFB50_F9C0);
    close_out;
  end
endmodule

`default_nettype wire
